// [hw/fbc_regs.svh]
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH

// Special program pages, steps and interrupt vectors
`define FBC_RESET_PAGE 6'h00
`define FBC_RESET_STEP 6'h00
`define FBC_IRQ_PAGE   6'h02
`define FBC_TBL_PAGE   6'h04
`define FBC_VEC_EXT_A  6'h00
`define FBC_VEC_EXT_B  6'h02
`define FBC_VEC_TIMER  6'h04
`define FBC_LAST_PAGE  6'h1F
`define FBC_LAST_STEP  6'h3F
`define FBC_STEP_ONE   6'h01

// Immediate, ROM word, RAM file and page fields
`define FBC_IMM_NIB    3:0
`define FBC_IMM_BYTE   7:0
`define FBC_IMM_PAGE   11:6
`define FBC_IMM_STEP   5:0
`define FBC_ROM_HI     7:4
`define FBC_ROM_LO     3:0
`define FBC_RAM_FILE   2:0
`define FBC_PAGE_ROM   4:0

`endif

// [hw/fbc_pkg.sv]
package fbc_pkg;

   typedef enum logic [4:0] {
      op_nop,
      op_load_imm,
      op_acc_to_aux,
      op_aux_to_acc,
      op_ram_to_acc,
      op_acc_to_ram,
      op_add,
      op_add_carry,
      op_add_skip_instr,
      op_set_carry,
      op_clr_carry,
      op_load_addr,
      op_exchange_instr,
      op_jump,
      op_call,
      op_return,
      op_table_lookup_instr
   } fbc_op_e;

   typedef enum logic {
      st_run,
      st_tbl
   } fbc_state_e;

   typedef struct packed {
      fbc_state_e st;
      logic [5:0] page_field;
      logic [5:0] step_counter;
      logic [3:0] accumulator;
      logic [3:0] aux_acc;
      logic       carry;
      logic [3:0] ram_file_sel;
      logic [3:0] ram_word_sel;
      logic [7:0] addr_save_reg;
      logic       skip;
      logic       alu_carry_out;
      logic       op_err;
      logic       irq_ack;
   } fbc_core_s;

   typedef struct packed {
      logic [1:0] wp;
      logic [2:0] level;
   } fbc_stk_s;

endpackage

// [hw/fbc_stk_if.sv]
`timescale 1ns/1ps
interface fbc_stk_if;
   logic        push;
   logic        pop;
   logic [11:0] wdata;
   logic [11:0] rdata;
   logic [2:0]  level;

   modport core (output push, output pop, output wdata, input rdata, input level);
   modport stk  (input push, input pop, input wdata, output rdata, output level);
endinterface

// [hw/fbc_stack.sv]
`timescale 1ns/1ps
module fbc_stack #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Core side
   fbc_stk_if.stk    stk
);
   import fbc_pkg::*;

   if (DEPTH != 4) begin : g_chk
      $error("fbc_stack serves exactly four levels");
   end

   logic [11:0] mem [DEPTH];
   fbc_stk_s    r;
   fbc_stk_s    n;

   // Circular store: a push beyond four levels overwrites the oldest entry
   always_comb begin
      n = r;
      if (stk.push) begin
         n.wp = r.wp + 2'h1;
         if (r.level != 3'h4) begin
            n.level = r.level + 3'h1;
         end
      end else if (stk.pop) begin
         n.wp = r.wp - 2'h1;
         if (r.level != 3'h0) begin
            n.level = r.level - 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge clk) begin
      if (stk.push) begin
         mem[r.wp] <= stk.wdata;
      end
   end

   assign stk.rdata = mem[r.wp - 2'h1];
   assign stk.level = r.level;

   AST_POP_LAST_PUSH: assert property (@(posedge clk) disable iff (!resetn)
      stk.push && !stk.pop |=> stk.rdata == $past(stk.wdata))
      else $error("pop does not return the last pushed level");

endmodule

// [hw/fbc_core.sv]
`timescale 1ns/1ps
`include "fbc_regs.svh"

module fbc_core #(
   parameter int RAM_WORDS = 128,
   parameter int ROM_STEPS = 2048,
   parameter int STK_DEPTH = 4
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            resetn,
   // Operation request
   input  wire logic            op_valid,
   input  wire fbc_pkg::fbc_op_e op_code,
   input  wire logic [11:0]     op_imm,
   output logic                 op_ready,
   output logic                 op_err,
   // Interrupt entry: bit 0 external A, bit 1 external B, bit 2 timer
   input  wire logic [2:0]      irq_req,
   output logic                 irq_ack,
   // Program loader
   input  wire logic            prog_we,
   input  wire logic [10:0]     prog_addr,
   input  wire logic [7:0]      prog_data,
   // Fetch
   output logic [7:0]           fetch_word,
   output logic                 fetch_valid,
   // Observed state
   output logic [11:0]          program_counter,
   output logic [3:0]           accumulator,
   output logic [3:0]           aux_acc,
   output logic                 carry_flag,
   output logic                 alu_carry_out,
   output logic                 skip_pending,
   output logic [3:0]           ram_file_sel,
   output logic [3:0]           ram_word_sel,
   output logic [7:0]           addr_save_reg,
   output logic [2:0]           stack_level
);
   import fbc_pkg::*;

   if (RAM_WORDS != 128 || ROM_STEPS != 2048 || STK_DEPTH != 4) begin : g_chk
      $error("fbc_core serves 128 RAM words, 2048 ROM steps, four stack levels");
   end

   logic [3:0] ram_mem [RAM_WORDS];
   logic [7:0] rom_mem [ROM_STEPS];
   logic [7:0] rom_q;

   fbc_core_s  r;
   fbc_core_s  n;
   fbc_stk_if  stk_bus ();

   logic [3:0]  ram_rd;
   logic        ram_we;
   logic [6:0]  ram_idx;
   logic [3:0]  add_b;
   logic        add_c;
   logic [4:0]  sum;
   logic [5:0]  step_inc;
   logic [10:0] rom_rd_addr;
   logic        fire;
   logic        irq_take;
   logic        tbl_start;

   function automatic logic [10:0] rom_index(input logic [5:0] page, input logic [5:0] step);
      rom_index = {page[`FBC_PAGE_ROM], step};
   endfunction

   // Fixed priority: external A, then external B, then timer
   function automatic logic [5:0] irq_vector(input logic [2:0] req);
      if (req[0]) begin
         irq_vector = `FBC_VEC_EXT_A;
      end else if (req[1]) begin
         irq_vector = `FBC_VEC_EXT_B;
      end else begin
         irq_vector = `FBC_VEC_TIMER;
      end
   endfunction

   function automatic logic page_ok(input logic [5:0] page);
      page_ok = page <= `FBC_LAST_PAGE;
   endfunction

   fbc_stack #(
      .DEPTH (STK_DEPTH)
   ) u_stack (
      .clk    (clk),
      .resetn (resetn),
      .stk    (stk_bus.stk)
   );

   assign ram_idx  = {r.ram_file_sel[`FBC_RAM_FILE], r.ram_word_sel};
   assign ram_rd   = ram_mem[ram_idx];
   assign op_ready = (r.st == st_run) && (irq_req == 3'h0);
   assign irq_take = (r.st == st_run) && (irq_req != 3'h0);
   assign fire     = op_valid && op_ready && !r.skip;
   assign step_inc = r.step_counter + `FBC_STEP_ONE;
   assign tbl_start = fire && (op_code == op_table_lookup_instr);

   // Shared adder; carry is only stored by the add-with-carry form
   always_comb begin
      add_b = (op_code == op_add_skip_instr) ? op_imm[`FBC_IMM_NIB] : ram_rd;
      add_c = (op_code == op_add_carry) ? r.carry : 1'b0;
      sum   = {1'b0, r.accumulator} + {1'b0, add_b} + {4'h0, add_c};
   end

   always_comb begin
      n             = r;
      n.op_err      = 1'b0;
      n.irq_ack     = 1'b0;
      ram_we        = 1'b0;
      stk_bus.push  = 1'b0;
      stk_bus.pop   = 1'b0;
      stk_bus.wdata = {r.page_field, step_inc};
      case (r.st)
         st_run: begin
            if (irq_take) begin
               stk_bus.push    = 1'b1;
               stk_bus.wdata   = {r.page_field, r.step_counter};
               n.page_field    = `FBC_IRQ_PAGE;
               n.step_counter  = irq_vector(irq_req);
               n.irq_ack       = 1'b1;
            end else if (op_valid && r.skip) begin
               // Skipped instruction still advances the step
               n.skip         = 1'b0;
               n.step_counter = step_inc;
            end else if (fire) begin
               n.step_counter = step_inc;
               case (op_code)
                  op_load_imm:   n.accumulator = op_imm[`FBC_IMM_NIB];
                  op_acc_to_aux: n.aux_acc = r.accumulator;
                  op_aux_to_acc: n.accumulator = r.aux_acc;
                  op_ram_to_acc: n.accumulator = ram_rd;
                  op_acc_to_ram: ram_we = 1'b1;
                  op_add: begin
                     n.accumulator   = sum[3:0];
                     n.alu_carry_out = sum[4];
                  end
                  op_add_carry: begin
                     n.accumulator   = sum[3:0];
                     n.alu_carry_out = sum[4];
                     n.carry         = sum[4];
                  end
                  op_add_skip_instr: begin
                     n.accumulator   = sum[3:0];
                     n.alu_carry_out = sum[4];
                     n.skip          = sum[4];
                  end
                  op_set_carry: n.carry = 1'b1;
                  op_clr_carry: n.carry = 1'b0;
                  op_load_addr: begin
                     {n.ram_file_sel, n.ram_word_sel} = op_imm[`FBC_IMM_BYTE];
                  end
                  op_exchange_instr: begin
                     {n.ram_file_sel, n.ram_word_sel} = r.addr_save_reg;
                     n.addr_save_reg = {r.ram_file_sel, r.ram_word_sel};
                  end
                  op_jump, op_call: begin
                     // Targets past the last page are refused and flagged
                     if (page_ok(op_imm[`FBC_IMM_PAGE])) begin
                        n.page_field   = op_imm[`FBC_IMM_PAGE];
                        n.step_counter = op_imm[`FBC_IMM_STEP];
                        stk_bus.push   = (op_code == op_call);
                     end else begin
                        n.op_err = 1'b1;
                     end
                  end
                  op_return: begin
                     stk_bus.pop = 1'b1;
                     {n.page_field, n.step_counter} = stk_bus.rdata;
                  end
                  op_table_lookup_instr: begin
                     stk_bus.push = 1'b1;
                     n.st         = st_tbl;
                  end
                  default: n.op_err = 1'b0;
               endcase
            end
         end
         st_tbl: begin
            // The table byte arrived in rom_q; return address comes back off the stack
            n.aux_acc     = rom_q[`FBC_ROM_HI];
            n.accumulator = rom_q[`FBC_ROM_LO];
            stk_bus.pop   = 1'b1;
            {n.page_field, n.step_counter} = stk_bus.rdata;
            n.st          = st_run;
         end
         default: n.st = st_run;
      endcase
   end

   // Table lookup reads page 04 at step {aux low bits, accumulator}
   always_comb begin
      if (tbl_start) begin
         rom_rd_addr = rom_index(`FBC_TBL_PAGE, {r.aux_acc[1:0], r.accumulator});
      end else begin
         rom_rd_addr = rom_index(n.page_field, n.step_counter);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r              <= '0;
         r.st           <= st_run;
         r.page_field   <= `FBC_RESET_PAGE;
         r.step_counter <= `FBC_RESET_STEP;
      end else begin
         r <= n;
      end
   end

   // Memories carry no reset; contents are undefined until written
   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram_mem[ram_idx] <= r.accumulator;
      end
      if (prog_we) begin
         rom_mem[prog_addr] <= prog_data;
      end
      rom_q <= rom_mem[rom_rd_addr];
   end

   assign fetch_word      = rom_q;
   assign fetch_valid     = (r.st == st_run);
   assign program_counter = {r.page_field, r.step_counter};
   assign accumulator     = r.accumulator;
   assign aux_acc         = r.aux_acc;
   assign carry_flag      = r.carry;
   assign alu_carry_out   = r.alu_carry_out;
   assign skip_pending    = r.skip;
   assign ram_file_sel    = r.ram_file_sel;
   assign ram_word_sel    = r.ram_word_sel;
   assign addr_save_reg   = r.addr_save_reg;
   assign stack_level     = stk_bus.level;
   assign op_err          = r.op_err;
   assign irq_ack         = r.irq_ack;

   AST_RESET_PAGE: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> program_counter == 12'h000)
      else $error("execution does not start at page zero");

   AST_ADC_CARRY: assert property (@(posedge clk) disable iff (!resetn)
      fire && op_code == op_add_carry |=> carry_flag == $past(sum[4]))
      else $error("add with carry did not store the carry");

   AST_ADD_KEEPS_C: assert property (@(posedge clk) disable iff (!resetn)
      fire && op_code == op_add |=> carry_flag == $past(carry_flag)
         && alu_carry_out == $past(sum[4]) && accumulator == $past(sum[3:0]))
      else $error("plain add disturbed the carry flag");

   AST_SKIP_NEXT: assert property (@(posedge clk) disable iff (!resetn)
      fire && op_code == op_add_skip_instr && sum[4] |=> skip_pending)
      else $error("carry of add with skip did not arm the skip");

   AST_SKIP_DISCARD: assert property (@(posedge clk) disable iff (!resetn)
      skip_pending && op_valid && op_ready |=> !skip_pending
         && accumulator == $past(accumulator)
         && program_counter[5:0] == $past(program_counter[5:0]) + 6'h01)
      else $error("skip did not discard the next instruction");

   AST_EXCHANGE: assert property (@(posedge clk) disable iff (!resetn)
      fire && op_code == op_exchange_instr |=>
         {ram_file_sel, ram_word_sel} == $past(addr_save_reg)
         && addr_save_reg == $past({ram_file_sel, ram_word_sel}))
      else $error("exchange did not swap address and save registers");

   AST_IRQ_VECTOR: assert property (@(posedge clk) disable iff (!resetn)
      irq_take && irq_req[1:0] == 2'b10 |=> program_counter == 12'h082 && irq_ack)
      else $error("second external interrupt vector wrong");

   AST_IRQ_PUSH: assert property (@(posedge clk) disable iff (!resetn)
      irq_take && stack_level < 3'h4 |=> stack_level == $past(stack_level) + 3'h1)
      else $error("interrupt entry did not push a level");

   AST_TABLE_LOAD: assert property (@(posedge clk) disable iff (!resetn)
      tbl_start |=> !fetch_valid ##1 ({aux_acc, accumulator} == $past(fetch_word)
         && fetch_valid && program_counter == $past(program_counter, 2) + 12'h001))
      else $error("table lookup did not load the pair and return");

   AST_PAGE_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
      program_counter[11:6] <= 6'h1F)
      else $error("program counter left the valid page range");

   AST_STEP_ADVANCE: assert property (@(posedge clk) disable iff (!resetn)
      fire && op_code == op_load_imm
         |=> program_counter[5:0] == $past(program_counter[5:0]) + 6'h01
         && program_counter[11:6] == $past(program_counter[11:6]))
      else $error("step counter did not advance within the page");

endmodule

// [test/tb_four_bit_core_datapath.sv]
`timescale 1ns/1ps
module tb_four_bit_core_datapath;
   import fbc_pkg::*;

   typedef struct {
      fbc_op_e    op;
      logic [11:0] imm;
      logic [3:0] acc;
      logic [3:0] aux;
      logic       c;
      logic       cy;
   } fbc_row_s;

   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        op_valid = 1'b0;
   fbc_op_e     op_code = op_nop;
   logic [11:0] op_imm = 12'h000;
   logic [2:0]  irq_req = 3'h0;
   logic        prog_we = 1'b0;
   logic [10:0] prog_addr = 11'h000;
   logic [7:0]  prog_data = 8'h00;
   logic        op_ready, op_err, irq_ack, fetch_valid, carry_flag, alu_carry_out, skip_pending;
   logic [7:0]  fetch_word, addr_save_reg;
   logic [11:0] program_counter;
   logic [3:0]  accumulator, aux_acc, ram_file_sel, ram_word_sel;
   logic [2:0]  stack_level;
   int          err_total = 0;
   int          checks = 0;
   logic [11:0] pc_exp = 12'h000;
   logic [11:0] stk [4];
   logic [2:0]  irqv [4] = '{3'h1, 3'h2, 3'h7, 3'h4};
   logic [11:0] vec [4] = '{12'h080, 12'h082, 12'h080, 12'h084};
   logic [7:0]  ram_a [3] = '{8'h00, 8'h7F, 8'h35};
   logic [3:0]  ram_v [3] = '{4'h3, 4'hC, 4'h6};
   // Rows run in order, so each row's expectation builds on the ones before
   fbc_row_s rows [13] = '{
      '{op_clr_carry,  12'h000, 4'h0, 4'h0, 1'b0, 1'b0},
      '{op_load_addr,  12'h012, 4'h0, 4'h0, 1'b0, 1'b0},
      '{op_load_imm,   12'h009, 4'h9, 4'h0, 1'b0, 1'b0},
      '{op_acc_to_ram, 12'h000, 4'h9, 4'h0, 1'b0, 1'b0},
      '{op_load_imm,   12'h008, 4'h8, 4'h0, 1'b0, 1'b0},
      '{op_acc_to_aux, 12'h000, 4'h8, 4'h8, 1'b0, 1'b0},
      '{op_set_carry,  12'h000, 4'h8, 4'h8, 1'b1, 1'b0},
      '{op_add_carry,  12'h000, 4'h2, 4'h8, 1'b1, 1'b1},
      '{op_add_carry,  12'h000, 4'hC, 4'h8, 1'b0, 1'b0},
      '{op_aux_to_acc, 12'h000, 4'h8, 4'h8, 1'b0, 1'b0},
      '{op_ram_to_acc, 12'h000, 4'h9, 4'h8, 1'b0, 1'b0},
      '{op_nop,        12'h000, 4'h9, 4'h8, 1'b0, 1'b0},
      '{op_add,        12'h000, 4'h2, 4'h8, 1'b0, 1'b1}};

   always #2 clk = ~clk;

   fbc_core dut_u (
      .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
      .op_ready(op_ready), .op_err(op_err), .irq_req(irq_req), .irq_ack(irq_ack),
      .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
      .fetch_word(fetch_word), .fetch_valid(fetch_valid), .program_counter(program_counter),
      .accumulator(accumulator), .aux_acc(aux_acc), .carry_flag(carry_flag),
      .alu_carry_out(alu_carry_out), .skip_pending(skip_pending), .ram_file_sel(ram_file_sel),
      .ram_word_sel(ram_word_sel), .addr_save_reg(addr_save_reg), .stack_level(stack_level));

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Ends at the falling edge after the taking edge, where results have landed
   task automatic do_op(input fbc_op_e op, input logic [11:0] imm);
      int n;
      n = 0;
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      op_imm <= imm;
      @(negedge clk);
      while (op_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      // A request that is never taken counts as a mismatch
      if (n == 50) begin
         err_total++;
         $display("Error op_ready expected 1 seen %b", op_ready);
      end
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
      pc_exp = pc_exp + 12'h001;
   endtask

   task automatic prog(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      prog_we <= 1'b1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge clk);
      prog_we <= 1'b0;
   endtask

   task automatic finish_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Whole run is under two hundred cycles; this is a generous margin
   initial begin
      #80000;
      err_total++;
      finish_test;
   end

   initial begin
      repeat (10) @(posedge clk);
      chk("pc in reset", 12'h000, program_counter);
      chk("stack in reset", 12'h000, stack_level);
      resetn <= 1'b1;
      @(negedge clk);
      chk("pc after reset", 12'h000, program_counter);
      prog(11'h000, 8'h3C);
      prog(11'h125, 8'hA7);
      prog(11'h7FF, 8'h5A);
      for (int i = 0; i < 13; i++) begin
         do_op(rows[i].op, rows[i].imm);
         chk("acc", rows[i].acc, accumulator);
         chk("aux", rows[i].aux, aux_acc);
         chk("carry", rows[i].c, carry_flag);
         chk("cy", rows[i].cy, alu_carry_out);
         chk("pc", pc_exp, program_counter);
      end
      chk("file", 12'h001, ram_file_sel);
      chk("word", 12'h002, ram_word_sel);
      do_op(op_load_imm, 12'h00F);
      do_op(op_add_skip_instr, 12'h001);
      chk("cy skip", 12'h001, alu_carry_out);
      chk("carry kept", 12'h000, carry_flag);
      chk("skip set", 12'h001, skip_pending);
      do_op(op_load_imm, 12'h005);
      chk("skipped acc", 12'h000, accumulator);
      chk("skip clear", 12'h000, skip_pending);
      chk("skipped pc", pc_exp, program_counter);
      do_op(op_add_skip_instr, 12'h001);
      do_op(op_load_imm, 12'h005);
      chk("no skip acc", 12'h005, accumulator);
      do_op(op_exchange_instr, 12'h000);
      chk("save", 12'h012, addr_save_reg);
      chk("addr", 12'h000, {ram_file_sel, ram_word_sel});
      do_op(op_exchange_instr, 12'h000);
      chk("addr back", 12'h012, {ram_file_sel, ram_word_sel});
      for (int i = 0; i < 3; i++) begin
         do_op(op_load_addr, {4'h0, ram_a[i]});
         do_op(op_load_imm, {8'h00, ram_v[i]});
         do_op(op_acc_to_ram, 12'h000);
      end
      for (int i = 0; i < 3; i++) begin
         do_op(op_load_addr, {4'h0, ram_a[i]});
         do_op(op_ram_to_acc, 12'h000);
         chk("ram", ram_v[i], accumulator);
      end
      do_op(op_load_imm, 12'h002);
      do_op(op_acc_to_aux, 12'h000);
      do_op(op_load_imm, 12'h005);
      do_op(op_table_lookup_instr, 12'h000);
      chk("tbl valid", 12'h000, fetch_valid);
      chk("tbl ready", 12'h000, op_ready);
      chk("tbl push", 12'h001, stack_level);
      chk("tbl byte", 12'h0A7, fetch_word);
      @(negedge clk);
      chk("tbl aux", 12'h00A, aux_acc);
      chk("tbl acc", 12'h007, accumulator);
      chk("tbl pop", 12'h000, stack_level);
      chk("tbl pc", pc_exp, program_counter);
      do_op(op_jump, 12'h7FF);
      @(negedge clk);
      chk("last pc", 12'h7FF, program_counter);
      chk("last word", 12'h05A, fetch_word);
      do_op(op_jump, 12'h0C5);
      do_op(op_jump, 12'h800);
      chk("bad page err", 12'h001, op_err);
      chk("bad page pc", 12'h0C6, program_counter);
      @(negedge clk);
      chk("err pulse", 12'h000, op_err);
      do_op(op_call, 12'h105);
      chk("call pc", 12'h105, program_counter);
      chk("call push", 12'h001, stack_level);
      do_op(op_return, 12'h000);
      chk("call ret pc", 12'h0C7, program_counter);
      chk("call ret level", 12'h000, stack_level);
      pc_exp = 12'h0C7;
      for (int i = 0; i < 4; i++) begin
         stk[i] = pc_exp;
         @(posedge clk);
         irq_req <= irqv[i];
         @(negedge clk);
         chk("irq blocks op", 12'h000, op_ready);
         @(posedge clk);
         irq_req <= 3'h0;
         @(negedge clk);
         chk("irq ack", 12'h001, irq_ack);
         chk("irq pc", vec[i], program_counter);
         chk("irq push", i + 1, stack_level);
         pc_exp = vec[i];
         @(negedge clk);
         chk("ack pulse", 12'h000, irq_ack);
      end
      for (int i = 3; i >= 0; i--) begin
         do_op(op_return, 12'h000);
         chk("ret pc", stk[i], program_counter);
         chk("ret level", i, stack_level);
      end
      // Asynchronous reset in mid-run: pc and accumulator clear before any clock edge
      @(posedge clk);
      resetn <= 1'b0;
      #1;
      chk("mid reset pc", 12'h000, program_counter);
      chk("mid reset acc", 12'h000, accumulator);
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(negedge clk);
      chk("restart pc", 12'h000, program_counter);
      chk("restart word", 12'h03C, fetch_word);
      finish_test;
   end
endmodule
